// ===== verilog/audio_record_pkg.sv
// constants for the record-path gain, rate and clock-source control block
// assumes a single 10 MHz control clock and sample strobes from the converters
package audio_record_pkg;
    // clock configuration register
    localparam logic [15:0] CLOCK_CONFIG_ADDR  = 16'ha037;
    localparam logic [7:0]  CLOCK_CONFIG_RESET = 8'h00;
    localparam int          CFG_RATE_LSB       = 0;
    localparam int          CFG_HALVE_BIT      = 3;
    localparam int          CFG_PIN_BIT        = 4;
    localparam int          CFG_REMAP_BIT      = 5;
    localparam int          CFG_SOURCE_BIT     = 7;
    // sample rate codes, slowest first
    localparam logic [3:0]  RATE_8K     = 4'h0;
    localparam logic [3:0]  RATE_11K025 = 4'h1;
    localparam logic [3:0]  RATE_12K    = 4'h2;
    localparam logic [3:0]  RATE_16K    = 4'h3;
    localparam logic [3:0]  RATE_22K05  = 4'h4;
    localparam logic [3:0]  RATE_24K    = 4'h5;
    localparam logic [3:0]  RATE_44K1   = 4'h6;
    localparam logic [3:0]  RATE_48K    = 4'h7;
    localparam logic [3:0]  RATE_88K2   = 4'h8;
    localparam logic [3:0]  RATE_96K    = 4'h9;
    // word length codes
    localparam logic [1:0]  WLEN_16 = 2'h0;
    localparam logic [1:0]  WLEN_20 = 2'h1;
    localparam logic [1:0]  WLEN_24 = 2'h2;
    // gain code limits, one code per documented step
    localparam logic [6:0]  DAC_VOL_MAX    = 7'h7f;
    localparam logic [3:0]  RECORD_CONVERTER_A_GAIN_MAX  = 4'hf;
    localparam logic [4:0]  MIX_GAIN_MAX   = 5'h1f;
    localparam logic [4:0]  MIX_ATTEN_MAX  = 5'h1f;
    // automatic gain control
    localparam logic [1:0]  AGC_CH_BOTH     = 2'h0;
    localparam logic [1:0]  AGC_CH_LEFT     = 2'h1;
    localparam logic [1:0]  AGC_CH_RIGHT    = 2'h2;
    localparam logic [3:0]  TARGET_MAX      = 4'he;
    localparam logic [5:0]  NOISE_MAX       = 6'h20;
    localparam logic [5:0]  NOISE_BASE_IDX  = 6'h10;
    localparam logic [4:0]  MIN_GAIN_MAX    = 5'h14;
    localparam logic [4:0]  AGC_GAIN_MAX    = 5'h1f;
    localparam logic [15:0] LIMIT_LEVEL     = 16'h7000;
    localparam logic [3:0]  RAMP_SET_MAX    = 4'ha;
    localparam logic [4:0]  DELAY_LOG2_OFS  = 5'h03;
    localparam logic [4:0]  DECAY_LOG2_OFS  = 5'h05;
    localparam logic [4:0]  ATTACK_LOG2_OFS = 5'h03;
    localparam logic [4:0]  BOOST_STEP      = 5'h07;
    localparam int          TIMER_W         = 19;
    typedef enum logic [1:0] {AGC_OFF, AGC_ATTACK, AGC_WAIT, AGC_DECAY} agc_state_t;
endpackage : audio_record_pkg

// ===== verilog/sink_rate_arbiter.sv
// picks, per record converter, the rate of its highest-priority sink
// sinks 0..3 are in priority order; outputs are combinational
`timescale 1ns/1ps
module sink_rate_arbiter (
    // sinks
    input  wire logic [3:0]  sink_en,
    input  wire logic [3:0]  sink_src,
    input  wire logic [15:0] sink_rate,
    // result
    output logic      [7:0]  conv_rate,
    output logic      [1:0]  conv_used,
    output logic      [3:0]  sink_mute
);
    logic [3:0] win_rate [2];
    logic       found    [2];

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            found[c]    = 1'b0;
            win_rate[c] = audio_record_pkg::RATE_48K;
            for (int s = 0; s < 4; s++) begin
                if (sink_en[s] && (int'(sink_src[s]) == c) && !found[c]) begin
                    found[c]    = 1'b1;
                    win_rate[c] = sink_rate[s*4 +: 4];
                end
            end
        end
        for (int s = 0; s < 4; s++) begin
            // losing sinks with a different rate go quiet
            sink_mute[s] = sink_en[s] && (sink_rate[s*4 +: 4] != win_rate[sink_src[s]]);
        end
        conv_rate = {win_rate[1], win_rate[0]};
        conv_used = {found[1], found[0]};
    end
endmodule : sink_rate_arbiter

// ===== verilog/agc_sample_timer.sv
// counts record samples; fires every 2^span_log2 samples and flags expiry
// sample_tick comes from the converter logic on the same clock
`timescale 1ns/1ps
module agc_sample_timer (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // control
    input  wire logic       sample_tick,
    input  wire logic       restart,
    input  wire logic       bypass,
    input  wire logic [4:0] span_log2,
    // status
    output logic            fire,
    output logic            expired
);
    localparam int W = audio_record_pkg::TIMER_W;
    logic [W-1:0] cnt_r;
    logic         expired_r;
    wire  [W-1:0] limit = (W'(1) << span_log2) - W'(1);

    assign fire    = sample_tick && !restart && (cnt_r == limit);
    assign expired = expired_r || bypass;

    always_ff @(posedge clk) begin
        if (sys_rst || restart) begin
            cnt_r     <= '0;
            expired_r <= 1'b0;
        end else if (sample_tick) begin
            cnt_r <= fire ? '0 : cnt_r + W'(1);
            if (fire) begin
                expired_r <= 1'b1;
            end
        end
    end
endmodule : agc_sample_timer

// ===== verilog/audio_record_gain_and_clocking.sv
// file holds the top level of the record/playback digital control
// assumes level and sample strobe from the record converter on clk
`timescale 1ns/1ps
module audio_record_gain_and_clocking (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // serial port settings, index 0 first port
    input  wire logic [7:0]  port_rate,
    input  wire logic [3:0]  port_wlen,
    input  wire logic [1:0]  port_out_en,
    input  wire logic [1:0]  port_out_src,
    // playback converters, index 0 is playback_converter_a
    input  wire logic [1:0]  dac_port_sel,
    input  wire logic [1:0]  dac_loop_en,
    input  wire logic [1:0]  dac_loop_src,
    input  wire logic [13:0] dac_vol,
    input  wire logic [1:0]  dac_mute,
    output logic      [7:0]  dac_rate,
    output logic      [3:0]  dac_wlen,
    output logic      [13:0] dac_atten,
    output logic      [1:0]  dac_mute_out,
    // record converters and sinks
    output logic      [7:0]  adc_rate,
    output logic      [3:0]  adc_wlen,
    output logic      [1:0]  adc_hpf_en,
    output logic      [1:0]  serial_out_mute,
    input  wire logic [3:0]  record_converter_a_gain,
    input  wire logic        record_converter_a_from_mixer,
    output logic      [3:0]  record_converter_a_gain_out,
    output logic             record_converter_a_mixer_sel,
    // mixer
    input  wire logic [19:0] mix_in_gain,
    input  wire logic [3:0]  mix_in_mute,
    input  wire logic [4:0]  mix_atten,
    output logic      [19:0] mix_in_gain_out,
    output logic      [3:0]  mix_in_mute_out,
    output logic      [4:0]  mix_atten_out,
    // gain control settings
    input  wire logic        agc_en,
    input  wire logic [1:0]  agc_channels,
    input  wire logic [3:0]  agc_target,
    input  wire logic [3:0]  agc_delay,
    input  wire logic [3:0]  agc_decay,
    input  wire logic [3:0]  agc_attack,
    input  wire logic [5:0]  agc_noise,
    input  wire logic [4:0]  agc_min_gain,
    input  wire logic [4:0]  agc_max_gain,
    input  wire logic [3:0]  prog_boost,
    input  wire logic [9:0]  prog_rec_gain,
    // record_converter_b level, same clock
    input  wire logic        rec_sample_tick,
    input  wire logic [15:0] rec_peak_left,
    input  wire logic [15:0] rec_peak_right,
    // effective record gain
    output logic      [3:0]  boost_out,
    output logic      [9:0]  rec_gain_out,
    output logic             agc_limiting,
    // clock source controls toward the audio PLL
    output logic             pll_ref_external,
    output logic             ext_clock_pin_sel,
    output logic             ext_clock_remap,
    output logic      [3:0]  ext_clock_rate
);
    // rate codes out of range fall back to 48 kHz, length codes to the nearest legal value
    function automatic logic [3:0] legal_rate(input logic [3:0] r);
        return (r > audio_record_pkg::RATE_96K) ? audio_record_pkg::RATE_48K : r;
    endfunction : legal_rate

    function automatic logic [1:0] legal_wlen(input logic [1:0] w);
        return (w > audio_record_pkg::WLEN_24) ? audio_record_pkg::WLEN_24 : w;
    endfunction : legal_wlen

    // level at idx*1.5 dB below full scale; 6 dB per shift is close enough here
    function automatic logic [15:0] db_to_level(input logic [5:0] idx);
        logic [15:0] base;
        case (idx[1:0])
            2'h0:    base = 16'h7fff;
            2'h1:    base = 16'h6bb3;
            2'h2:    base = 16'h5a9d;
            default: base = 16'h4c3f;
        endcase
        return base >> idx[5:2];
    endfunction : db_to_level

    function automatic logic [3:0] clamp4(input logic [3:0] v, input logic [3:0] lim);
        return (v > lim) ? lim : v;
    endfunction : clamp4

    // clock configuration register
    logic [7:0] clk_cfg_r;
    wire        cfg_hit = (reg_addr == audio_record_pkg::CLOCK_CONFIG_ADDR);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clk_cfg_r <= audio_record_pkg::CLOCK_CONFIG_RESET;
            reg_rdata <= 8'h00;
        end else begin
            if (reg_wr && cfg_hit) begin
                clk_cfg_r <= reg_wdata;
            end
            if (reg_rd) begin
                reg_rdata <= cfg_hit ? clk_cfg_r : 8'h00;
            end
        end
    end

    wire cfg_ext = clk_cfg_r[audio_record_pkg::CFG_SOURCE_BIT];
    // rate and halve bits mean nothing on the internal source
    wire [3:0] cfg_rate_code = cfg_ext ?
        {clk_cfg_r[audio_record_pkg::CFG_HALVE_BIT],
         clk_cfg_r[audio_record_pkg::CFG_RATE_LSB +: 3]} : 4'h0;

    // sinks in priority order: serial out 1, serial out 2, playback a, playback b
    wire [3:0] port_rate_c = legal_rate(port_rate[3:0]);
    wire [3:0] port_rate_d = legal_rate(port_rate[7:4]);
    wire [3:0] dac_rate_a  = dac_port_sel[0] ? port_rate_d : port_rate_c;
    wire [3:0] dac_rate_b  = dac_port_sel[1] ? port_rate_d : port_rate_c;
    wire [1:0] wlen_c      = legal_wlen(port_wlen[1:0]);
    wire [1:0] wlen_d      = legal_wlen(port_wlen[3:2]);
    wire [1:0] dac_wlen_a  = dac_port_sel[0] ? wlen_d : wlen_c;
    wire [1:0] dac_wlen_b  = dac_port_sel[1] ? wlen_d : wlen_c;
    wire [7:0] conv_rate;
    wire [1:0] conv_used;
    wire [3:0] sink_mute;

    // output direction of each port reuses the port's one rate
    sink_rate_arbiter u_arb (
        .sink_en   ({dac_loop_en, port_out_en}),
        .sink_src  ({dac_loop_src, port_out_src}),
        .sink_rate ({dac_rate_b, dac_rate_a, port_rate_d, port_rate_c}),
        .conv_rate (conv_rate),
        .conv_used (conv_used),
        .sink_mute (sink_mute)
    );

    // record length follows the first serial output using that converter
    wire [1:0] adc_wlen_a = (port_out_en[0] && !port_out_src[0]) ? wlen_c : wlen_d;
    wire [1:0] adc_wlen_b = (port_out_en[0] && port_out_src[0]) ? wlen_c : wlen_d;

    // playback volume: one code per 0.75 dB of attenuation
    wire [6:0] vol_a = (dac_vol[6:0] > audio_record_pkg::DAC_VOL_MAX) ?
                       audio_record_pkg::DAC_VOL_MAX : dac_vol[6:0];
    wire [6:0] vol_b = (dac_vol[13:7] > audio_record_pkg::DAC_VOL_MAX) ?
                       audio_record_pkg::DAC_VOL_MAX : dac_vol[13:7];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dac_rate        <= {audio_record_pkg::RATE_48K, audio_record_pkg::RATE_48K};
            dac_wlen        <= {audio_record_pkg::WLEN_16, audio_record_pkg::WLEN_16};
            adc_rate        <= {audio_record_pkg::RATE_48K, audio_record_pkg::RATE_48K};
            adc_wlen        <= {audio_record_pkg::WLEN_16, audio_record_pkg::WLEN_16};
            adc_hpf_en      <= 2'h3;
            dac_atten       <= 14'h3fff;
            dac_mute_out    <= 2'h3;
            serial_out_mute <= 2'h3;
            record_converter_a_gain_out   <= 4'h0;
            record_converter_a_mixer_sel  <= 1'b0;
            mix_in_gain_out <= 20'hfffff;
            mix_in_mute_out <= 4'hf;
            mix_atten_out   <= audio_record_pkg::MIX_ATTEN_MAX;
        end else begin
            dac_rate        <= {dac_rate_b, dac_rate_a};
            dac_wlen        <= {dac_wlen_b, dac_wlen_a};
            adc_rate        <= conv_rate;
            adc_wlen        <= {adc_wlen_b, adc_wlen_a};
            adc_hpf_en      <= 2'h3;
            dac_atten       <= {vol_b, vol_a};
            dac_mute_out    <= dac_mute | sink_mute[3:2];
            serial_out_mute <= sink_mute[1:0];
            record_converter_a_gain_out   <= clamp4(record_converter_a_gain, audio_record_pkg::RECORD_CONVERTER_A_GAIN_MAX);
            record_converter_a_mixer_sel  <= record_converter_a_from_mixer;
            mix_in_gain_out <= mix_in_gain;
            mix_in_mute_out <= mix_in_mute;
            mix_atten_out   <= mix_atten;
        end
    end

    // level sensing on the selected channels of record_converter_b
    wire use_left  = (agc_channels != audio_record_pkg::AGC_CH_RIGHT);
    wire use_right = (agc_channels != audio_record_pkg::AGC_CH_LEFT);
    wire [15:0] lvl_left  = use_left ? rec_peak_left : 16'h0000;
    wire [15:0] lvl_right = use_right ? rec_peak_right : 16'h0000;
    wire [15:0] sense_lvl = (lvl_left > lvl_right) ? lvl_left : lvl_right;

    wire [3:0]  tgt_code   = clamp4(agc_target, audio_record_pkg::TARGET_MAX);
    wire [15:0] tgt_level  = db_to_level({2'b00, tgt_code} + 6'h01);
    wire [5:0]  noise_code = (agc_noise > audio_record_pkg::NOISE_MAX) ?
                             audio_record_pkg::NOISE_MAX : agc_noise;
    wire [15:0] gate_level = db_to_level(audio_record_pkg::NOISE_BASE_IDX + noise_code);
    wire        above      = sense_lvl > tgt_level;
    wire        gated      = sense_lvl < gate_level;
    wire        over_limit = sense_lvl > audio_record_pkg::LIMIT_LEVEL;

    // gain bounds; a minimum above the maximum yields to the maximum
    wire [4:0] min_code = (agc_min_gain > audio_record_pkg::MIN_GAIN_MAX) ?
                          audio_record_pkg::MIN_GAIN_MAX : agc_min_gain;
    wire [4:0] hi_bound = agc_max_gain;
    wire [4:0] lo_bound = (min_code > hi_bound) ? hi_bound : min_code;

    audio_record_pkg::agc_state_t state_r, state_nxt;
    logic [4:0] gain_r, gain_nxt;
    logic       limit_r;

    // limiter holds until a sample is at or below 87.5% of full scale
    wire       limit_now   = over_limit || (limit_r && state_r != audio_record_pkg::AGC_OFF);
    wire [3:0] attack_set  = limit_now ? 4'h0 : clamp4(agc_attack, audio_record_pkg::RAMP_SET_MAX);
    wire [3:0] decay_set   = clamp4(agc_decay, audio_record_pkg::RAMP_SET_MAX);
    // full ramp is 32 gain codes, so one code takes 1/32 of the ramp time
    wire [4:0] attack_span = {1'b0, attack_set} + audio_record_pkg::ATTACK_LOG2_OFS;
    wire [4:0] decay_span  = {1'b0, decay_set} + audio_record_pkg::DECAY_LOG2_OFS;
    wire [4:0] delay_span  = {1'b0, agc_delay} + audio_record_pkg::DELAY_LOG2_OFS;
    wire [4:0] step_span   = (state_r == audio_record_pkg::AGC_ATTACK) ? attack_span : decay_span;

    wire delay_restart = !agc_en || (rec_sample_tick && above);
    wire step_restart  = (state_nxt != state_r);
    wire delay_done;
    wire step_fire;

    agc_sample_timer u_delay (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .sample_tick (rec_sample_tick),
        .restart     (delay_restart),
        .bypass      (agc_delay == 4'h0),
        .span_log2   (delay_span),
        .fire        (),
        .expired     (delay_done)
    );

    agc_sample_timer u_step (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .sample_tick (rec_sample_tick),
        .restart     (step_restart),
        .bypass      (1'b0),
        .span_log2   (step_span),
        .fire        (step_fire),
        .expired     ()
    );

    always_comb begin
        state_nxt = state_r;
        gain_nxt  = gain_r;
        case (state_r)
            audio_record_pkg::AGC_OFF: begin
                gain_nxt = lo_bound;
                if (agc_en) begin
                    state_nxt = audio_record_pkg::AGC_WAIT;
                end
            end
            audio_record_pkg::AGC_ATTACK: begin
                if (step_fire && gain_r > lo_bound) begin
                    gain_nxt = gain_r - 5'h01;
                end
                if (rec_sample_tick && !above) begin
                    state_nxt = audio_record_pkg::AGC_WAIT;
                end
            end
            audio_record_pkg::AGC_WAIT: begin
                if (rec_sample_tick && above) begin
                    state_nxt = audio_record_pkg::AGC_ATTACK;
                end else if (delay_done) begin
                    state_nxt = audio_record_pkg::AGC_DECAY;
                end
            end
            audio_record_pkg::AGC_DECAY: begin
                if (step_fire && !gated && gain_r < hi_bound) begin
                    gain_nxt = gain_r + 5'h01;
                end
                if (rec_sample_tick && above) begin
                    state_nxt = audio_record_pkg::AGC_ATTACK;
                end
            end
            default: begin
                state_nxt = audio_record_pkg::AGC_OFF;
            end
        endcase
        if (gain_nxt < lo_bound) begin
            gain_nxt = lo_bound;
        end
        if (gain_nxt > hi_bound) begin
            gain_nxt = hi_bound;
        end
        if (!agc_en) begin
            state_nxt = audio_record_pkg::AGC_OFF;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= audio_record_pkg::AGC_OFF;
            gain_r  <= 5'h00;
            limit_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            gain_r  <= gain_nxt;
            if (!agc_en) begin
                limit_r <= 1'b0;
            end else if (rec_sample_tick) begin
                limit_r <= over_limit;
            end
        end
    end

    // split total gain: coarse boost in 7-code steps, remainder digital
    wire [1:0] agc_boost = (gain_r >= 5'(3 * audio_record_pkg::BOOST_STEP)) ? 2'h3 :
                           (gain_r >= 5'(2 * audio_record_pkg::BOOST_STEP)) ? 2'h2 :
                           (gain_r >= audio_record_pkg::BOOST_STEP) ? 2'h1 : 2'h0;
    wire [4:0] agc_digital = gain_r - 5'(agc_boost * audio_record_pkg::BOOST_STEP);
    wire       ctl_left    = agc_en && use_left;
    wire       ctl_right   = agc_en && use_right;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            boost_out         <= 4'h0;
            rec_gain_out      <= 10'h000;
            agc_limiting      <= 1'b0;
            pll_ref_external  <= 1'b0;
            ext_clock_pin_sel <= 1'b0;
            ext_clock_remap   <= 1'b0;
            ext_clock_rate    <= 4'h0;
        end else begin
            boost_out[1:0]    <= ctl_left ? agc_boost : prog_boost[1:0];
            boost_out[3:2]    <= ctl_right ? agc_boost : prog_boost[3:2];
            rec_gain_out[4:0] <= ctl_left ? agc_digital : prog_rec_gain[4:0];
            rec_gain_out[9:5] <= ctl_right ? agc_digital : prog_rec_gain[9:5];
            agc_limiting      <= agc_en && limit_now;
            pll_ref_external  <= cfg_ext;
            ext_clock_pin_sel <= clk_cfg_r[audio_record_pkg::CFG_PIN_BIT];
            ext_clock_remap   <= clk_cfg_r[audio_record_pkg::CFG_REMAP_BIT];
            ext_clock_rate    <= cfg_rate_code;
        end
    end
endmodule : audio_record_gain_and_clocking

// ===== tb/audio_record_properties.sv
// checker for the clock config register and converter mute and filter outputs
// bound to the top module; one clock, synchronous reset
`timescale 1ns/1ps
module audio_record_checker (
    input logic        clk, sys_rst, reg_wr, reg_rd,
    input logic [15:0] reg_addr,
    input logic [7:0]  reg_wdata, reg_rdata,
    input logic        pll_ref_external, ext_clock_pin_sel, ext_clock_remap,
    input logic [3:0]  ext_clock_rate,
    input logic [1:0]  adc_hpf_en, dac_mute, dac_mute_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire wr_cfg = reg_wr && reg_addr == 16'ha037;
    wire wr_ext = wr_cfg && reg_wdata[7];
    property p_src; wr_cfg |-> ##2 pll_ref_external == $past(reg_wdata[7], 2); endproperty
    a_src: assert property (p_src) else $error("clock source bit");
    property p_pin; wr_cfg |-> ##2 ext_clock_pin_sel == $past(reg_wdata[4], 2); endproperty
    a_pin: assert property (p_pin) else $error("pin select bit");
    property p_remap; wr_cfg |-> ##2 ext_clock_remap == $past(reg_wdata[5], 2); endproperty
    a_remap: assert property (p_remap) else $error("remap bit");
    property p_ext; wr_ext |-> ##2 ext_clock_rate == $past(reg_wdata[3:0], 2); endproperty
    a_ext: assert property (p_ext) else $error("rate field");
    property p_int; !pll_ref_external |-> ext_clock_rate == 4'h0; endproperty
    a_int: assert property (p_int) else $error("rate with internal source");
    property p_unm; reg_rd && reg_addr != 16'ha037 |=> reg_rdata == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    property p_hpf; adc_hpf_en == 2'h3; endproperty
    a_hpf: assert property (p_hpf) else $error("dc filter off");
    property p_mute; dac_mute[0] |=> dac_mute_out[0]; endproperty
    a_mute: assert property (p_mute) else $error("playback mute");
    c_ext: cover property (wr_ext);
    c_clash: cover property (dac_mute_out[0] && !dac_mute[0]);
    c_rd: cover property (reg_rd && !wr_cfg);
endmodule : audio_record_checker
bind audio_record_gain_and_clocking audio_record_checker u_chk (.*);

// ===== tb/host_port_model.sv
// host side of the two serial ports: rate, length and output routing
// one frame clock per port, so a single rate field serves both directions
`timescale 1ns/1ps
module host_port_model (
    input  logic       clk,
    output logic [7:0] port_rate,
    output logic [3:0] port_wlen,
    output logic [1:0] port_out_en, port_out_src
);
    initial {port_rate, port_wlen, port_out_en, port_out_src} = '0;
    task automatic cfg(input logic [7:0] r, input logic [3:0] w, input logic [3:0] o);
        @(posedge clk);
        port_rate <= r;
        port_wlen <= w;
        {port_out_en, port_out_src} <= o;
    endtask : cfg
endmodule : host_port_model

// ===== tb/tb.sv
// bench: config register, rate clash between sinks, setting copies
// host_port_model drives the serial port settings
`timescale 1ns/1ps
module tb;
    logic clk, sys_rst, reg_wr, reg_rd, record_converter_a_from_mixer, agc_en, rec_sample_tick, record_converter_a_mixer_sel;
    logic agc_limiting, pll_ref_external, ext_clock_pin_sel, ext_clock_remap;
    logic [15:0] reg_addr, rec_peak_left, rec_peak_right;
    logic [7:0] reg_wdata, reg_rdata, port_rate, dac_rate, adc_rate;
    logic [3:0] port_wlen, dac_wlen, adc_wlen, record_converter_a_gain, record_converter_a_gain_out, mix_in_mute, boost_out;
    logic [3:0] mix_in_mute_out, agc_target, agc_delay, agc_decay, agc_attack, prog_boost;
    logic [3:0] ext_clock_rate;
    logic [1:0] port_out_en, port_out_src, dac_port_sel, dac_loop_en, dac_loop_src, dac_mute;
    logic [1:0] dac_mute_out, adc_hpf_en, serial_out_mute, agc_channels;
    logic [13:0] dac_vol, dac_atten;
    logic [19:0] mix_in_gain, mix_in_gain_out;
    logic [4:0] mix_atten, mix_atten_out, agc_min_gain, agc_max_gain;
    logic [5:0] agc_noise;
    logic [9:0] prog_rec_gain, rec_gain_out;
    int fails = 0, samples_checked = 0;
    audio_record_gain_and_clocking u_dut (.*);
    host_port_model u_host (.*);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, e);
    endtask : rd
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            rec_sample_tick <= 1'b1;
            @(posedge clk);
            rec_sample_tick <= 1'b0;
        end
    endtask : tick
    task automatic tally_and_finish;
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    initial begin
        {reg_wr, reg_rd, record_converter_a_from_mixer, agc_en, rec_sample_tick, reg_addr, rec_peak_left,
         rec_peak_right, reg_wdata, record_converter_a_gain, mix_in_mute, agc_target, agc_delay, agc_decay,
         agc_attack, prog_boost, dac_port_sel, dac_loop_en, dac_loop_src, dac_mute, agc_channels,
         dac_vol, mix_in_gain, mix_atten, agc_min_gain, agc_max_gain, agc_noise, prog_rec_gain} = '0;
        sys_rst = 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        rd(16'ha037, 8'h00);
        wr(16'ha037, 8'hfd);
        check({pll_ref_external, ext_clock_pin_sel, ext_clock_remap, ext_clock_rate}, 7'h7d);
        rd(16'ha037, 8'hfd);
        wr(16'ha037, 8'h1b);
        check({pll_ref_external, ext_clock_pin_sel, ext_clock_remap, ext_clock_rate}, 7'h20);
        wr(16'ha036, 8'hff);
        rd(16'ha036, 8'h00);
        rd(16'ha037, 8'h1b);
        u_host.cfg(8'h63, 4'h2, 4'h4);
        dac_port_sel <= 2'b01;
        dac_loop_en <= 2'b01;
        @(posedge clk);
        #1 check({adc_rate[3:0], dac_rate[3:0], dac_mute_out, serial_out_mute}, 12'h364);
        check({adc_wlen[1:0], dac_wlen[1:0]}, 4'h8);
        u_host.cfg(8'h33, 4'h2, 4'h4);
        record_converter_a_gain <= 4'hf;
        dac_vol <= 14'h3f80;
        dac_mute <= 2'b10;
        mix_in_gain <= 20'h12345;
        mix_in_mute <= 4'h5;
        mix_atten <= 5'h0a;
        record_converter_a_from_mixer <= 1'b1;
        @(posedge clk);
        #1 check({dac_mute_out, serial_out_mute}, 4'h8);
        check({record_converter_a_gain_out, dac_atten, adc_hpf_en}, 20'hffe03);
        check({mix_in_gain_out, mix_in_mute_out, mix_atten_out, record_converter_a_mixer_sel}, 30'h48d1555);
        // left-only gain control; a loud right channel must not be sensed
        @(posedge clk);
        {agc_en, agc_channels, agc_max_gain, agc_attack} <= {1'b1, 2'h1, 5'h1f, 4'ha};
        {prog_boost, prog_rec_gain} <= {4'hf, 10'h3ff};
        {rec_peak_left, rec_peak_right} <= {16'h1000, 16'h7fff};
        repeat (3) @(posedge clk);
        #1 check({boost_out, rec_gain_out}, 14'h33e0);
        tick(31);
        @(posedge clk);
        #1 check({boost_out, rec_gain_out}, 14'h33e0);
        tick(1);
        @(posedge clk);
        #1 check({boost_out, rec_gain_out}, 14'h33e1);
        // slow attack setting: only the limiter can step down within 8 samples
        @(posedge clk) rec_peak_left <= 16'h7800;
        tick(9);
        @(posedge clk);
        #1 check({agc_limiting, boost_out, rec_gain_out}, 15'h73e0);
        tally_and_finish();
    end
    initial begin
        repeat (2000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
endmodule : tb
